// file: rai_pkg.sv
package rai_pkg;

	// register word addresses on the modbus register map
	localparam logic [15:0] RAI_ADDR_MAIN_MAP = 16'h0BE4;
	localparam logic [15:0] RAI_ADDR_EARLY_MAP = 16'h0BE6;

	// bit positions shared by both relay state maps
	localparam int RAI_BIT_PREV_ALARM = 0;
	localparam int RAI_BIT_INS_ALARM = 4;
	localparam int RAI_BIT_INJ_INHIBIT = 8;
	localparam int RAI_BIT_SYS_ERROR = 16;
	localparam int RAI_BIT_PROD_ERROR = 24;

	// values after reset or factory reset
	localparam logic [31:0] RAI_MAIN_MAP_RESET = 32'h01010010;
	localparam logic [31:0] RAI_EARLY_MAP_RESET = 32'h00000010;

	// bits software may write, per map
	localparam logic [31:0] RAI_MAIN_WR_MASK = 32'h01010101;
	localparam logic [31:0] RAI_EARLY_WR_MASK = 32'h01010110;

	// early warning relay drive mode
	typedef enum logic [1:0] {
		RAI_MODE_FAILSAFE,
		RAI_MODE_STANDARD,
		RAI_MODE_MIRROR
	} rai_relay_mode_t;

	// inhibition input contact type
	typedef enum logic [1:0] {
		RAI_INH_NO,
		RAI_INH_NC,
		RAI_INH_OFF
	} rai_inhibit_cfg_t;

	// settings held elsewhere in the device
	typedef struct packed {
		rai_relay_mode_t early_warning_relay_mode;
		logic main_relay_failsafe;
		logic prev_threshold_off;
		logic ack_inhibit_on;
		rai_inhibit_cfg_t inhibit_input_mode;
		logic modbus_inhibit;
		logic device_operative;
	} rai_cfg_t;

	// raw device conditions from the measurement side
	typedef struct packed {
		logic prev_alarm;
		logic ins_alarm;
		logic disconnected_injection;
		logic overvoltage;
		logic overcapacitance;
		logic product_error;
		logic autotest_fail;
	} rai_states_t;

	// register access request from the modbus engine or the panel
	typedef struct packed {
		logic valid;
		logic write;
		logic from_modbus;
		logic [15:0] addr;
		logic [31:0] wdata;
	} rai_req_t;

	// register access answer
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} rai_rsp_t;

	// drive outputs toward relays and injector
	typedef struct packed {
		logic main_fault_relay;
		logic early_warning_relay;
		logic injection_enable;
		logic injection_inhibited;
		logic system_error;
	} rai_relay_out_t;

	// whole state of the main module
	typedef struct packed {
		logic [31:0] main_map;
		logic [31:0] early_map;
		logic ack_inhibit_prev;
		logic pin_meta;
		logic pin_sync;
		rai_rsp_t rsp;
		rai_relay_out_t out;
	} rai_state_t;

endpackage

// file: rai_relay_drive.sv
`timescale 1ns/10ps
// one relay: assigned condition and drive polarity
module rai_relay_drive
	import rai_pkg::*;
(
	input wire logic [31:0] state_map,
	input wire logic [31:0] active_states,
	input wire logic failsafe,
	input wire logic operative,
	output logic drive
);

	// any assigned state currently active
	logic assigned_active;

	always_comb
	begin
		assigned_active = |(state_map & active_states);
		if (!operative)
		begin
			// inoperative product leaves the coil de-energized
			drive = 1'b0;
		end
		else if (failsafe)
		begin
			// failsafe: energized while nothing assigned is active
			drive = ~assigned_active;
		end
		else
		begin
			// standard: energized while an assigned state is active
			drive = assigned_active;
		end
	end

endmodule

// file: rai_relay_assign.sv
`timescale 1ns/10ps
// What this block does
// - bit 0 preventive alarm, read-only early map
// - bit 4 insulation alarm, read-only main map
// - inhibit bit 8, system 16, product 24
// - system error from four causes, autotest too
// - main map 3044, early map 3046
// - factory reset main: alarm, system, product
// - factory reset early: insulation alarm only
// - threshold not off sets early bit 0
// - mirror mode clears early map, refuses writes
// - ack inhibit off clears bit 8 both
// - ack inhibit switched on sets main bit 8
// - input polarity NO or NC selectable
// - input OFF ignores pin, modbus still works
// - inhibition input stops this unit injecting
// - maps writable only over modbus
// - mirror follows main relay, both drop while inoperative
module rai_relay_assign
	import rai_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire rai_req_t req,
	output rai_rsp_t rsp,
	input wire rai_cfg_t cfg,
	input wire rai_states_t states,
	input wire logic inhibit_contact_pin,
	input wire logic factory_reset,
	output rai_relay_out_t relays
);

	// registered state of the whole block
	rai_state_t state_reg;
	// value the state takes at the next edge
	rai_state_t state_next;

	// product error including failed auto-test
	logic product_err;
	// any of the system error causes
	logic system_err;
	// inhibit request seen on the contact pin
	logic pin_inhibit;
	// injection held off by pin or modbus
	logic inhibited;
	// live states in map bit layout
	logic [31:0] active_states;
	// early map held cleared while mirroring
	logic early_locked;
	// main fault relay coil drive
	logic main_drive;
	// early warning relay coil drive from its own map
	logic early_drive;
	// request addresses one of the two maps
	logic hit_main;
	logic hit_early;
	// write granted into each map
	logic main_wr_ok;
	logic early_wr_ok;
	// map words after a granted write
	logic [31:0] main_wr_word;
	logic [31:0] early_wr_word;
	// ack inhibit setting switched on this cycle
	logic ack_inhibit_rise;
	// early warning coil drive before registering
	logic early_relay_next;

	// live state vector in map layout
	always_comb
	begin
		// auto-test failure counts as product error
		product_err = states.product_error | states.autotest_fail;
		system_err = states.disconnected_injection | states.overvoltage
			| states.overcapacitance | product_err;
		unique case (cfg.inhibit_input_mode)
			RAI_INH_NO:
			begin
				// closed contact stops injection
				pin_inhibit = state_reg.pin_sync;
			end
			RAI_INH_NC:
			begin
				// open contact stops injection
				pin_inhibit = ~state_reg.pin_sync;
			end
			RAI_INH_OFF:
			begin
				pin_inhibit = 1'b0;
			end
			default:
			begin
				// undefined setting treated as off
				pin_inhibit = 1'b0;
			end
		endcase
		inhibited = pin_inhibit | cfg.modbus_inhibit;
		// states placed at their bit positions
		active_states = 32'h00000000;
		active_states[RAI_BIT_PREV_ALARM] = states.prev_alarm;
		active_states[RAI_BIT_INS_ALARM] = states.ins_alarm;
		active_states[RAI_BIT_INJ_INHIBIT] = inhibited;
		active_states[RAI_BIT_SYS_ERROR] = system_err;
		active_states[RAI_BIT_PROD_ERROR] = product_err;
		// early map held cleared in mirror mode
		early_locked = (cfg.early_warning_relay_mode == RAI_MODE_MIRROR);
	end

	// main fault relay condition and polarity
	rai_relay_drive u_main_drive
	(
		.state_map(state_reg.main_map),
		.active_states(active_states),
		.failsafe(cfg.main_relay_failsafe),
		.operative(cfg.device_operative),
		.drive(main_drive)
	);

	// early warning relay condition and polarity
	rai_relay_drive u_early_drive
	(
		.state_map(state_reg.early_map),
		.active_states(active_states),
		.failsafe(cfg.early_warning_relay_mode == RAI_MODE_FAILSAFE),
		.operative(cfg.device_operative),
		.drive(early_drive)
	);

	// write decode: which map a request may change
	always_comb
	begin
		// address hits on the two maps
		hit_main = (req.addr == RAI_ADDR_MAIN_MAP);
		hit_early = (req.addr == RAI_ADDR_EARLY_MAP);
		main_wr_ok = req.valid && req.write && req.from_modbus && hit_main;
		// mirror mode refuses early map writes
		early_wr_ok = req.valid && req.write && req.from_modbus && hit_early
			&& !early_locked;
		// read-only and reserved bits keep their value
		main_wr_word = (state_reg.main_map & ~RAI_MAIN_WR_MASK)
			| (req.wdata & RAI_MAIN_WR_MASK);
		// early bit 0 is never taken from a write
		early_wr_word = (state_reg.early_map & ~RAI_EARLY_WR_MASK)
			| (req.wdata & RAI_EARLY_WR_MASK);
		// rising edge of the ack inhibit setting
		ack_inhibit_rise = cfg.ack_inhibit_on && !state_reg.ack_inhibit_prev;
	end

	// next state: sync, bus access, map housekeeping, outputs
	always_comb
	begin
		// hold everything unless changed below
		state_next = state_reg;
		// two-stage sync of the contact pin, first stage read only here
		state_next.pin_meta = inhibit_contact_pin;
		state_next.pin_sync = state_reg.pin_meta;
		// answer strobes last one cycle
		state_next.rsp.ack = 1'b0;
		state_next.rsp.err = 1'b0;
		state_next.rsp.rdata = 32'h00000000;
		state_next.ack_inhibit_prev = cfg.ack_inhibit_on;

		// register access
		if (req.valid)
		begin
			// every request is answered one cycle later
			state_next.rsp.ack = 1'b1;
			unique case (req.addr)
				RAI_ADDR_MAIN_MAP:
				begin
					// reserved bits are stored as zero
					state_next.rsp.rdata = state_reg.main_map;
					// write path of the main map
					if (req.write)
					begin
						if (main_wr_ok)
						begin
							state_next.main_map = main_wr_word;
						end
						else
						begin
							state_next.rsp.err = 1'b1;
						end
					end
				end
				RAI_ADDR_EARLY_MAP:
				begin
					// early map returned as stored
					state_next.rsp.rdata = state_reg.early_map;
					// write path of the early map
					if (req.write)
					begin
						if (early_wr_ok)
						begin
							state_next.early_map = early_wr_word;
						end
						else
						begin
							state_next.rsp.err = 1'b1;
						end
					end
				end
				default:
				begin
					// unmapped address answers error, reads zero
					state_next.rsp.err = 1'b1;
				end
			endcase
		end

		if (factory_reset)
		begin
			// defaults replace whatever software wrote
			state_next.main_map = RAI_MAIN_MAP_RESET;
			state_next.early_map = RAI_EARLY_MAP_RESET;
		end

		// insulation alarm always assigned to main relay
		state_next.main_map[RAI_BIT_INS_ALARM] = 1'b1;

		// inhibit bit locked clear while ack off
		if (!cfg.ack_inhibit_on)
		begin
			// neither relay may carry the inhibit state
			state_next.main_map[RAI_BIT_INJ_INHIBIT] = 1'b0;
			state_next.early_map[RAI_BIT_INJ_INHIBIT] = 1'b0;
		end
		// switching ack on assigns inhibit to main relay
		else if (ack_inhibit_rise)
		begin
			// once per switch-on, software may clear it later
			state_next.main_map[RAI_BIT_INJ_INHIBIT] = 1'b1;
		end

		state_next.early_map[RAI_BIT_PREV_ALARM] = ~cfg.prev_threshold_off;

		// mirror mode keeps early map cleared
		if (early_locked)
		begin
			// writable and forced bits alike read zero
			state_next.early_map = 32'h00000000;
		end

		if (early_locked)
		begin
			// mirrored coil drops when the product is inoperative
			early_relay_next = main_drive & cfg.device_operative;
		end
		else
		begin
			early_relay_next = early_drive;
		end
		state_next.out.early_warning_relay = early_relay_next;
		state_next.out.main_fault_relay = main_drive;
		state_next.out.injection_enable = ~inhibited;
		// inverse kept for the injector status
		state_next.out.injection_inhibited = inhibited;
		// system error state shown directly
		state_next.out.system_error = system_err;
	end

	// state register
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_reg.main_map <= RAI_MAIN_MAP_RESET;
			state_reg.early_map <= RAI_EARLY_MAP_RESET;
			// ack setting counts as off until first seen
			state_reg.ack_inhibit_prev <= 1'b0;
			// sync chain starts from an open contact
			state_reg.pin_meta <= 1'b0;
			state_reg.pin_sync <= 1'b0;
			// no answer and no coil drive during reset
			state_reg.rsp <= '0;
			state_reg.out <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// outputs straight from flops
	assign rsp = state_reg.rsp;
	assign relays = state_reg.out;

endmodule

// file: rai_relay_assign_chk.sv
`timescale 1ns/10ps
// port-level checks of the relay assignment block
module rai_relay_assign_chk
	import rai_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire rai_req_t req,
	input wire rai_rsp_t rsp,
	input wire rai_cfg_t cfg,
	input wire rai_states_t states,
	input wire logic inhibit_contact_pin,
	input wire logic factory_reset,
	input wire rai_relay_out_t relays
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// any of the system error causes
	wire logic sys_cause = |states[4:0];
	ack_timing_a: assert property (##1 rsp.ack == $past(req.valid))
		else $error("ack timing");
	unmapped_err_a: assert property (req.valid && req.addr != RAI_ADDR_MAIN_MAP
		&& req.addr != RAI_ADDR_EARLY_MAP |=> rsp.err && rsp.rdata == 32'h00000000)
		else $error("unmapped access");
	panel_refused_a: assert property (req.valid && req.write && !req.from_modbus |=> rsp.err)
		else $error("panel write taken");
	mirror_refused_a: assert property (req.valid && req.write && req.addr == RAI_ADDR_EARLY_MAP
		&& cfg.early_warning_relay_mode == RAI_MODE_MIRROR |=> rsp.err)
		else $error("mirror write taken");
	sys_error_a: assert property (##1 relays.system_error == $past(sys_cause))
		else $error("system error");
	inj_pair_a: assert property (!$past(rst) |-> relays.injection_enable != relays.injection_inhibited)
		else $error("inject pair");
	input_off_a: assert property (cfg.inhibit_input_mode == RAI_INH_OFF
		|=> relays.injection_inhibited == $past(cfg.modbus_inhibit))
		else $error("input off");
	contact_no_a: assert property ((cfg.inhibit_input_mode == RAI_INH_NO && inhibit_contact_pin)[*4]
		|=> relays.injection_inhibited)
		else $error("contact no");
	main_fs_a: assert property (cfg.main_relay_failsafe && states.ins_alarm |=> !relays.main_fault_relay)
		else $error("failsafe main");
	mirror_follow_a: assert property (cfg.early_warning_relay_mode == RAI_MODE_MIRROR
		|=> relays.early_warning_relay == relays.main_fault_relay)
		else $error("mirror follow");
endmodule

// file: rai_master_model.sv
`timescale 1ns/10ps
// modbus master plus breaker auxiliary contacts
module rai_master_model
	import rai_pkg::*;
(
	input wire logic mclk,
	input wire rai_rsp_t rsp,
	input wire logic first_feeder_breaker,
	input wire logic second_feeder_breaker,
	input wire logic nc_wiring,
	output rai_req_t req,
	output logic inhibit_contact_pin
);
	logic [31:0] rd;
	assign inhibit_contact_pin = (first_feeder_breaker & second_feeder_breaker) ^ nc_wiring;
	initial req = '0;
	// one-cycle request, answer read after next edge
	task automatic access(input logic w, input logic mb, input logic [15:0] a,
		input logic [31:0] d, output logic err);
		@(posedge mclk);
		req <= '{1'b1, w, mb, a, d};
		@(posedge mclk);
		req.valid <= 1'b0;
		#1;
		rd = rsp.rdata;
		err = rsp.ack ? rsp.err : 1'bx;
	endtask
endmodule

// file: rai_relay_assign_test.sv
`timescale 1ns/10ps
`define C(n, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module rai_relay_assign_test
	import rai_pkg::*;
;
	localparam logic [15:0] MA = RAI_ADDR_MAIN_MAP;
	localparam logic [15:0] EA = RAI_ADDR_EARLY_MAP;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	rai_cfg_t cfg = '{RAI_MODE_STANDARD, 1'b0, 1'b1, 1'b0, RAI_INH_OFF, 1'b0, 1'b1};
	rai_states_t states = '0;
	logic factory_reset = 1'b0;
	logic f1 = 1'b0;
	logic f2 = 1'b0;
	logic ncw = 1'b0;
	rai_req_t req;
	rai_rsp_t rsp;
	rai_relay_out_t relays;
	logic pin;
	logic err;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	always #50 mclk = ~mclk;
	rai_relay_assign uut (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp), .cfg(cfg),
		.states(states), .inhibit_contact_pin(pin), .factory_reset(factory_reset),
		.relays(relays));
	rai_master_model m (.mclk(mclk), .rsp(rsp), .first_feeder_breaker(f1),
		.second_feeder_breaker(f2), .nc_wiring(ncw), .req(req), .inhibit_contact_pin(pin));
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic ee);
		m.access(1'b0, 1'b1, a, 32'h00000000, err);
		`C("rdata", e, m.rd)
		`C("err", ee, err)
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic mb, input logic ee);
		m.access(1'b1, mb, a, d, err);
		`C("err", ee, err)
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			test_done;
		end
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd(MA, 32'h01010010, 1'b0);
		rd(EA, 32'h00000010, 1'b0);
		rd(16'h0BE5, 32'h00000000, 1'b1);
		wr(MA, 32'hFFFFFFFF, 1'b1, 1'b0);
		rd(MA, 32'h01010011, 1'b0);
		wr(EA, 32'hFFFFFFFF, 1'b1, 1'b0);
		rd(EA, 32'h01010010, 1'b0);
		wr(MA, 32'h00000000, 1'b1, 1'b0);
		wr(MA, 32'h01000000, 1'b0, 1'b1);
		rd(MA, 32'h00000010, 1'b0);
		$display("bit access done");
		@(posedge mclk);
		cfg.ack_inhibit_on <= 1'b1;
		cfg.prev_threshold_off <= 1'b0;
		rd(MA, 32'h00000110, 1'b0);
		wr(EA, 32'h00000100, 1'b1, 1'b0);
		wr(MA, 32'h00000000, 1'b1, 1'b0);
		rd(MA, 32'h00000010, 1'b0);
		rd(EA, 32'h00000101, 1'b0);
		@(posedge mclk);
		cfg.early_warning_relay_mode <= RAI_MODE_MIRROR;
		rd(EA, 32'h00000000, 1'b0);
		wr(EA, 32'h00000100, 1'b1, 1'b1);
		@(posedge mclk);
		cfg.early_warning_relay_mode <= RAI_MODE_STANDARD;
		rd(EA, 32'h00000001, 1'b0);
		@(posedge mclk);
		cfg.prev_threshold_off <= 1'b1;
		factory_reset <= 1'b1;
		@(posedge mclk);
		factory_reset <= 1'b0;
		rd(MA, 32'h01010010, 1'b0);
		rd(EA, 32'h00000010, 1'b0);
		$display("map modes done");
		for (int md = 0; md < 3; md++)
			for (int k = 0; k < 4; k++)
			begin
				@(posedge mclk);
				cfg.inhibit_input_mode <= rai_inhibit_cfg_t'(md);
				f1 <= k[0];
				f2 <= k[1];
				ncw <= (md == 1);
				tick(5);
				`C("inject", !(md != 2 && k == 3), relays.injection_enable)
				`C("inhibited", (md != 2 && k == 3), relays.injection_inhibited)
			end
		@(posedge mclk);
		cfg.modbus_inhibit <= 1'b1;
		tick(2);
		`C("inject", 1'b0, relays.injection_enable)
		@(posedge mclk);
		cfg.modbus_inhibit <= 1'b0;
		$display("inhibit input done");
		for (int f = 0; f < 2; f++)
			for (int i = 0; i < 7; i++)
			begin
				@(posedge mclk);
				cfg.main_relay_failsafe <= f[0];
				cfg.early_warning_relay_mode <= f ? RAI_MODE_FAILSAFE : RAI_MODE_STANDARD;
				states <= rai_states_t'(7'h01 << i);
				tick(2);
				`C("sys", (i <= 4), relays.system_error)
				`C("main", (i <= 5) ^ f[0], relays.main_fault_relay)
				`C("early", (i == 5) ^ f[0], relays.early_warning_relay)
			end
		@(posedge mclk);
		cfg.main_relay_failsafe <= 1'b0;
		cfg.early_warning_relay_mode <= RAI_MODE_MIRROR;
		states <= rai_states_t'(7'h20);
		tick(2);
		`C("mirror", 1'b1, relays.early_warning_relay)
		@(posedge mclk);
		cfg.device_operative <= 1'b0;
		tick(2);
		`C("main", 1'b0, relays.main_fault_relay)
		`C("mirror", 1'b0, relays.early_warning_relay)
		$display("relay drive done");
		test_done;
	end
endmodule
bind rai_relay_assign rai_relay_assign_chk chk (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp),
	.cfg(cfg), .states(states), .inhibit_contact_pin(inhibit_contact_pin),
	.factory_reset(factory_reset), .relays(relays));
